// >>> pllc_pkg.sv
// Package of the fractional PLL divider control: control word layout,
// field widths, reset values and fast charge-pump delay timing.
// Assumes a single 100 MHz clock and a 146-bit control frame from the bus receiver.
package pllc_pkg;

  localparam int unsigned CLK_FREQ_MHZ = 100;

  // Control frame, bit numbers as received
  localparam int unsigned WORD_W       = 146;
  localparam int unsigned BIT_SEL_N    = 5;
  localparam int unsigned BIT_DLY_SEL  = 18;
  localparam int unsigned BIT_DLY1_LO  = 20;
  localparam int unsigned BIT_DLY2_LO  = 22;
  localparam int unsigned BIT_SHIFT    = 32;
  localparam int unsigned BIT_SPUR     = 60;
  localparam int unsigned BIT_HC_SEL   = 62;
  localparam int unsigned BIT_LC_SEL   = 63;
  localparam int unsigned BIT_N1_LO    = 80;
  localparam int unsigned BIT_N2_LO    = 102;
  localparam int unsigned BIT_R_LO     = 124;
  localparam int unsigned BIT_FRAC     = 144;
  localparam int unsigned BIT_LF_SEL   = 145;

  localparam int unsigned N_W          = 18;
  localparam int unsigned R_W          = 14;
  localparam int unsigned DLY_W        = 2;
  localparam int unsigned SHIFT_BITS   = 2;
  localparam int unsigned CNT_W        = 20;
  localparam int unsigned PRE_W        = 4;
  localparam logic [PRE_W-1:0] PRE_MAX = 4'ha;

  // Reset values of the latched settings
  localparam logic [N_W-1:0] N_RESET   = 18'h00000;
  localparam logic [R_W-1:0] R_RESET   = 14'h0000;
  localparam logic           BIT_RESET = 1'b0;

  // High-current pump hold time per delay code, in microseconds
  localparam int unsigned FAST_DLY1_US = 250;
  localparam int unsigned FAST_DLY2_US = 500;
  localparam int unsigned FAST_DLY3_US = 1000;
  localparam int unsigned FAST_DLY1_CYC = FAST_DLY1_US * CLK_FREQ_MHZ;
  localparam int unsigned FAST_DLY2_CYC = FAST_DLY2_US * CLK_FREQ_MHZ;
  localparam int unsigned FAST_DLY3_CYC = FAST_DLY3_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {
    PLLC_LOCKED = 2'b01,
    PLLC_FAST   = 2'b10
  } pllc_pump_mode_t;

endpackage : pllc_pkg

// >>> pllc_div_if.sv
// Interface between the control core and one programmable divider.
// Assumes the core owns the modulus and the divider returns one pulse per cycle.
`timescale 1ns/100ps
`default_nettype none
interface pllc_div_if;
  logic [17:0] modulus;
  logic        in_tick;
  logic        out_tick;

  modport ctrl (output modulus, output in_tick, input out_tick);
  modport div  (input modulus, input in_tick, output out_tick);
endinterface : pllc_div_if
`default_nettype wire

// >>> pllc_divider.sv
// Programmable pulse divider: one out_tick per modulus input ticks.
// Assumes in_tick is a one-cycle enable synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pllc_divider
  import pllc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  pllc_div_if.div   port_div
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        out_tick;
  } pllc_div_state_t;

  pllc_div_state_t st;
  pllc_div_state_t next_st;

  always_comb begin
    next_st          = st;
    next_st.out_tick = 1'b0;
    if (port_div.in_tick) begin
      // A modulus of 0 or 1 passes every tick rather than stalling
      if (port_div.modulus <= 18'h00001 || st.cnt >= port_div.modulus - 18'h00001) begin
        next_st.cnt      = 18'h00000;
        next_st.out_tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 18'h00001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port_div.out_tick = st.out_tick;
endmodule : pllc_divider
`default_nettype wire

// >>> pllc_phase_cmp.sv
// Phase-frequency comparator driving charge-pump source and sink requests.
// Assumes both inputs are one-cycle pulses from the dividers.
`timescale 1ns/100ps
`default_nettype none
module pllc_phase_cmp (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ref_pulse,
  input  wire logic fb_pulse,
  output logic      source_req,
  output logic      sink_req
);
  typedef struct packed {
    logic up;
    logic down;
  } pllc_pfd_state_t;

  pllc_pfd_state_t st;
  pllc_pfd_state_t next_st;

  always_comb begin
    next_st      = st;
    next_st.up   = st.up | ref_pulse;
    next_st.down = st.down | fb_pulse;
    // Both edges seen: the phase error ends, clear both requests
    if (next_st.up && next_st.down) begin
      next_st.up   = 1'b0;
      next_st.down = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign source_req = st.up;
  assign sink_req   = st.down;
endmodule : pllc_phase_cmp
`default_nettype wire

// >>> pllc_core.sv
// Control core of the fractional-N PLL: divider latches, shift and
// fractional logic, fast charge-pump timing, loop-filter and spur enables,
// AM prescaler. Assumes ctrl_word is a complete frame presented with a
// one-cycle ctrl_load, and vco_tick / ref_tick are synchronous enables.
//
// Functional notes
// - Two 18-bit feedback divider latches and one 14-bit reference latch.
// - One control bit selects which feedback latch drives the divider.
// - Shift bit low divides both divider values by four.
// - In shift mode the two low reference bits are not used.
// - Fractional mode uses the two low bits of the selected feedback value.
// - Fractional plus shift mode divides alternately by N or N+1.
// - Fractional off in shift mode divides only by N.
// - Four fractional positions: full, quarter, half, three quarters.
// - Phase comparator drives sink and source pump requests from both dividers.
// - One bit chooses which of two fast-pump delay settings applies.
// - First delay code at bits 20-21, second at bits 22-23.
// - Fast pump runs for the delay after a change, 1 or 2 mA.
// - Afterwards the low pump current applies, 50 or 100 uA.
// - A zero delay code keeps the fast pump off entirely.
// - One bit selects the AM or FM loop-filter pin, band independent.
// - Spur bit set enables wire switch and correction pump.
// - AM prescaler divides the VCO by one up to ten.
`timescale 1ns/100ps
`default_nettype none
module pllc_core
  import pllc_pkg::*;
#(
  parameter int unsigned FAST_DLY1 = FAST_DLY1_CYC,
  parameter int unsigned FAST_DLY2 = FAST_DLY2_CYC,
  parameter int unsigned FAST_DLY3 = FAST_DLY3_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [WORD_W-1:0] ctrl_word,
  input  wire logic              ctrl_load,
  input  wire logic              vco_tick,
  input  wire logic              ref_tick,
  input  wire logic [PRE_W-1:0]  am_ratio,
  output logic                   fb_div_pulse,
  output logic                   ref_div_pulse,
  output logic                   pump_source,
  output logic                   pump_sink,
  output logic                   high_pump_en,
  output logic                   high_pump_2ma,
  output logic                   low_pump_100ua,
  output logic                   loop_filter_sel,
  output logic                   spur_wire_switch_en,
  output logic                   spur_correction_en,
  output logic                   fast_pump_active,
  output logic                   am_lo_tick
);

  typedef struct packed {
    logic [N_W-1:0]   first_feedback_value;
    logic [N_W-1:0]   second_feedback_value;
    logic [R_W-1:0]   ref_value;
    logic             sel_second;
    logic             shift_off;
    logic             frac_off;
    logic             dly_sel_second;
    logic [DLY_W-1:0] fast_pump_delay_first;
    logic [DLY_W-1:0] fast_pump_delay_second;
    logic             spur_en;
    logic             hc_sel;
    logic             lc_sel;
    logic             lf_sel;
    logic [1:0]       fraction_accumulator;
    logic             plus_one;
    pllc_pump_mode_t  mode;
    logic [CNT_W-1:0] dly_cnt;
    logic             high_en;
    logic [PRE_W-1:0] pre_cnt;
    logic             am_lo;
  } pllc_core_state_t;

  pllc_core_state_t st;
  pllc_core_state_t next_st;

  pllc_div_if fb_if ();
  pllc_div_if ref_if ();

  logic [N_W-1:0]   active_n;
  logic [N_W-1:0]   loaded_active_n;
  logic [1:0]       frac_bits;
  logic             frac_active;
  logic [DLY_W-1:0] active_code;
  logic [DLY_W-1:0] loaded_code;
  logic [2:0]       acc_sum;
  logic [PRE_W-1:0] pre_div;

  // Hold time of the fast pump per delay code; code 0 means off
  function automatic logic [CNT_W-1:0] dly_cycles(input logic [DLY_W-1:0] code);
    logic [CNT_W-1:0] cyc;
    cyc = '0;
    unique case (code)
      2'h1: cyc = CNT_W'(FAST_DLY1);
      2'h2: cyc = CNT_W'(FAST_DLY2);
      2'h3: cyc = CNT_W'(FAST_DLY3);
      2'h0: cyc = '0;
    endcase
    return cyc;
  endfunction : dly_cycles

  always_comb begin
    active_n        = st.sel_second ? st.second_feedback_value
                                    : st.first_feedback_value;
    loaded_active_n = ctrl_word[BIT_SEL_N] ? ctrl_word[BIT_N2_LO +: N_W]
                                           : ctrl_word[BIT_N1_LO +: N_W];
    frac_bits       = active_n[SHIFT_BITS-1:0];
    frac_active     = !st.shift_off && !st.frac_off;
    active_code     = st.dly_sel_second ? st.fast_pump_delay_second
                                        : st.fast_pump_delay_first;
    loaded_code     = ctrl_word[BIT_DLY_SEL] ? ctrl_word[BIT_DLY2_LO +: DLY_W]
                                             : ctrl_word[BIT_DLY1_LO +: DLY_W];
    acc_sum         = {1'b0, st.fraction_accumulator} + {1'b0, frac_bits};
    // Ratios 0 and above ten are taken as no division
    if (am_ratio == '0 || am_ratio > PRE_MAX) begin
      pre_div = 4'h1;
    end else begin
      pre_div = am_ratio;
    end
  end

  // Feedback modulus: N, or in shift mode shifted N plus one on accumulator overflow
  always_comb begin
    if (st.shift_off) begin
      fb_if.modulus = active_n;
    end else begin
      fb_if.modulus = (active_n >> SHIFT_BITS) + {17'h00000, st.plus_one};
    end
    fb_if.in_tick = vco_tick;
  end

  // Reference modulus; the two low bits simply drop out of the shift
  always_comb begin
    if (st.shift_off) begin
      ref_if.modulus = {4'h0, st.ref_value};
    end else begin
      ref_if.modulus = {6'h00, st.ref_value[R_W-1:SHIFT_BITS]};
    end
    ref_if.in_tick = ref_tick;
  end

  always_comb begin
    next_st       = st;
    next_st.am_lo = 1'b0;

    // Latch a complete control frame
    if (ctrl_load) begin
      next_st.first_feedback_value   = ctrl_word[BIT_N1_LO +: N_W];
      next_st.second_feedback_value  = ctrl_word[BIT_N2_LO +: N_W];
      next_st.ref_value              = ctrl_word[BIT_R_LO +: R_W];
      next_st.sel_second             = ctrl_word[BIT_SEL_N];
      next_st.shift_off              = ctrl_word[BIT_SHIFT];
      next_st.frac_off               = ctrl_word[BIT_FRAC];
      next_st.dly_sel_second         = ctrl_word[BIT_DLY_SEL];
      next_st.fast_pump_delay_first  = ctrl_word[BIT_DLY1_LO +: DLY_W];
      next_st.fast_pump_delay_second = ctrl_word[BIT_DLY2_LO +: DLY_W];
      next_st.spur_en                = ctrl_word[BIT_SPUR];
      next_st.hc_sel                 = ctrl_word[BIT_HC_SEL];
      next_st.lc_sel                 = ctrl_word[BIT_LC_SEL];
      next_st.lf_sel                 = ctrl_word[BIT_LF_SEL];
    end

    // Fractional accumulator steps once per feedback divider cycle
    if (!frac_active) begin
      next_st.fraction_accumulator = 2'h0;
      next_st.plus_one             = 1'b0;
    end else if (fb_if.out_tick) begin
      // Quarter steps: accumulating 1, 2 or 3 overflows 1, 2 or 3 times in 4
      next_st.fraction_accumulator = acc_sum[1:0];
      next_st.plus_one             = acc_sum[2];
    end

    // Fast pump timing
    unique case (st.mode)
      PLLC_LOCKED: begin
        next_st.high_en = 1'b0;
      end
      PLLC_FAST: begin
        // A code cleared to zero while running stops the fast pump at once
        if (st.dly_cnt <= CNT_W'(1) || active_code == '0) begin
          next_st.mode    = PLLC_LOCKED;
          next_st.high_en = 1'b0;
          next_st.dly_cnt = '0;
        end else begin
          next_st.dly_cnt = st.dly_cnt - CNT_W'(1);
        end
      end
      default: begin
        next_st.mode    = PLLC_LOCKED;
        next_st.high_en = 1'b0;
        next_st.dly_cnt = '0;
      end
    endcase

    // A frame that changes the active divider is a frequency change
    if (ctrl_load && loaded_active_n != active_n) begin
      if (loaded_code == '0) begin
        next_st.mode    = PLLC_LOCKED;
        next_st.high_en = 1'b0;
        next_st.dly_cnt = '0;
      end else begin
        next_st.mode    = PLLC_FAST;
        next_st.high_en = 1'b1;
        next_st.dly_cnt = dly_cycles(loaded_code);
      end
    end

    // AM prescaler on the VCO enable
    if (vco_tick) begin
      if (st.pre_cnt >= pre_div - 4'h1) begin
        next_st.pre_cnt = '0;
        next_st.am_lo   = 1'b1;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.first_feedback_value   <= N_RESET;
      st.second_feedback_value  <= N_RESET;
      st.ref_value              <= R_RESET;
      st.sel_second             <= BIT_RESET;
      st.shift_off              <= BIT_RESET;
      st.frac_off               <= BIT_RESET;
      st.dly_sel_second         <= BIT_RESET;
      st.fast_pump_delay_first  <= '0;
      st.fast_pump_delay_second <= '0;
      st.spur_en                <= BIT_RESET;
      st.hc_sel                 <= BIT_RESET;
      st.lc_sel                 <= BIT_RESET;
      st.lf_sel                 <= BIT_RESET;
      st.fraction_accumulator   <= 2'h0;
      st.plus_one               <= 1'b0;
      st.mode                   <= PLLC_LOCKED;
      st.dly_cnt                <= '0;
      st.high_en                <= 1'b0;
      st.pre_cnt                <= '0;
      st.am_lo                  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  pllc_divider u_fb_div (
    .clk      (clk),
    .rst      (rst),
    .port_div (fb_if.div)
  );

  pllc_divider u_ref_div (
    .clk      (clk),
    .rst      (rst),
    .port_div (ref_if.div)
  );

  pllc_phase_cmp u_phase_comparator (
    .clk        (clk),
    .rst        (rst),
    .ref_pulse  (ref_if.out_tick),
    .fb_pulse   (fb_if.out_tick),
    .source_req (pump_source),
    .sink_req   (pump_sink)
  );

  assign fb_div_pulse        = fb_if.out_tick;
  assign ref_div_pulse       = ref_if.out_tick;
  assign high_pump_en        = st.high_en;
  assign high_pump_2ma       = st.hc_sel;
  assign low_pump_100ua      = st.lc_sel;
  assign loop_filter_sel     = st.lf_sel;
  assign spur_wire_switch_en = st.spur_en;
  assign spur_correction_en  = st.spur_en;
  assign fast_pump_active    = st.mode == PLLC_FAST;
  assign am_lo_tick          = st.am_lo;

endmodule : pllc_core
`default_nettype wire

// >>> pllc_core_checker.sv
// Checker for pllc_core: pump settings, fast-pump start, phase requests.
// Assumes only the top ports are seen; bound to every pllc_core.
`timescale 1ns/100ps
`default_nettype none
module pllc_core_checker
  import pllc_pkg::*;
#(
  parameter int unsigned FAST_DLY1 = FAST_DLY1_CYC,
  parameter int unsigned FAST_DLY2 = FAST_DLY2_CYC,
  parameter int unsigned FAST_DLY3 = FAST_DLY3_CYC
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [WORD_W-1:0] ctrl_word,
  input wire logic              ctrl_load,
  input wire logic              vco_tick,
  input wire logic              fb_div_pulse,
  input wire logic              ref_div_pulse,
  input wire logic              pump_source,
  input wire logic              pump_sink,
  input wire logic              high_pump_en,
  input wire logic              high_pump_2ma,
  input wire logic              low_pump_100ua,
  input wire logic              spur_wire_switch_en,
  input wire logic              spur_correction_en
);
  logic [N_W-1:0]   act_n;
  logic [CNT_W-1:0] hp_run;
  wire logic [N_W-1:0] new_n = ctrl_word[BIT_SEL_N] ? ctrl_word[BIT_N2_LO +: N_W] : ctrl_word[BIT_N1_LO +: N_W];
  wire logic [1:0] new_code = ctrl_word[BIT_DLY_SEL] ? ctrl_word[BIT_DLY2_LO +: 2] : ctrl_word[BIT_DLY1_LO +: 2];

  // Mirrors the active feedback value so a restart can be predicted
  always_ff @(posedge clk) begin
    if (rst) begin
      act_n <= N_RESET;
    end else if (ctrl_load) begin
      act_n <= new_n;
    end
  end

  // Length of the current fast-pump run; a new frame may restart the timer
  always_ff @(posedge clk) begin
    if (rst || !high_pump_en || ctrl_load) begin
      hp_run <= '0;
    end else begin
      hp_run <= hp_run + CNT_W'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hc_sel; ctrl_load |=> high_pump_2ma == $past(ctrl_word[BIT_HC_SEL]); endproperty
  a_hc_sel: assert property (p_hc_sel) else $error("fast pump current select wrong");
  property p_lc_sel; ctrl_load |=> low_pump_100ua == $past(ctrl_word[BIT_LC_SEL]); endproperty
  a_lc_sel: assert property (p_lc_sel) else $error("low pump current select wrong");
  property p_spur; ctrl_load |=> {spur_wire_switch_en, spur_correction_en} == {2{$past(ctrl_word[BIT_SPUR])}}; endproperty
  a_spur: assert property (p_spur) else $error("spur enables wrong");
  property p_start; ctrl_load && new_n != act_n && new_code != 2'h0 |=> high_pump_en; endproperty
  a_start: assert property (p_start) else $error("fast pump did not start");
  property p_zero; ctrl_load && new_code == 2'h0 && !high_pump_en |=> !high_pump_en; endproperty
  a_zero: assert property (p_zero) else $error("fast pump on with zero code");
  property p_source; ref_div_pulse && !fb_div_pulse && !pump_sink |=> pump_source; endproperty
  a_source: assert property (p_source) else $error("source request missing");
  property p_sink; fb_div_pulse && !ref_div_pulse && !pump_source |=> pump_sink; endproperty
  a_sink: assert property (p_sink) else $error("sink request missing");
  property p_fb_cause; fb_div_pulse |-> $past(vco_tick); endproperty
  a_fb_cause: assert property (p_fb_cause) else $error("divider pulse without tick");
  property p_hold_max; high_pump_en |-> hp_run < CNT_W'(FAST_DLY3); endproperty
  a_hold_max: assert property (p_hold_max) else $error("fast pump held too long");
endmodule : pllc_core_checker

bind pllc_core pllc_core_checker #(.FAST_DLY1(FAST_DLY1), .FAST_DLY2(FAST_DLY2), .FAST_DLY3(FAST_DLY3)) u_chk (
  .clk(clk), .rst(rst), .ctrl_word(ctrl_word), .ctrl_load(ctrl_load), .vco_tick(vco_tick),
  .fb_div_pulse(fb_div_pulse), .ref_div_pulse(ref_div_pulse), .pump_source(pump_source),
  .pump_sink(pump_sink), .high_pump_en(high_pump_en), .high_pump_2ma(high_pump_2ma),
  .low_pump_100ua(low_pump_100ua), .spur_wire_switch_en(spur_wire_switch_en),
  .spur_correction_en(spur_correction_en));
`default_nettype wire

// >>> pllc_analog_model.sv
// Behavioural VCO and reference oscillator feeding the core's tick inputs.
// Assumes slow selects a lazy VCO; pump requests bend the VCO rate.
`timescale 1ns/100ps
`default_nettype none
module pllc_analog_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic pump_source,
  input  wire logic pump_sink,
  output logic      vco_tick,
  output logic      ref_tick
);
  logic [1:0] ph;
  // Falling-edge updates so the core samples settled ticks
  always @(negedge clk) begin
    if (rst) begin
      ph <= 2'h0;
      vco_tick <= 1'b0;
      ref_tick <= 1'b0;
    end else begin
      ph <= (ph == (slow ? 2'h2 : 2'h1)) ? 2'h0 : ph + 2'h1;
      ref_tick <= (ph == 2'h0);
      // Source speeds the VCO up, sink holds it back
      vco_tick <= pump_source || (!pump_sink && (!slow || ph[0]));
    end
  end
endmodule : pllc_analog_model
`default_nettype wire

// >>> pllc_core_tb_top.sv
// Bench for pllc_core: frames, divider periods in ticks, fast pump, AM LO.
// Assumes the analog model supplies ticks; a monitor compares tick windows.
`timescale 1ns/100ps
`default_nettype none
module pllc_core_tb_top;
  import pllc_pkg::*;
  localparam int unsigned D1 = 5;
  localparam int unsigned D2 = 10;
  localparam int unsigned D3 = 20;
  typedef struct {int k; int total;} pllc_exp_t;
  logic              clk;
  logic              rst;
  logic              slow;
  logic              ctrl_load;
  logic [WORD_W-1:0] ctrl_word;
  logic [PRE_W-1:0]  am_ratio;
  logic vco_tick, ref_tick, fb_div_pulse, ref_div_pulse, pump_source, pump_sink, hp_d;
  logic high_pump_en, high_pump_2ma, low_pump_100ua, loop_filter_sel, fast_pump_active;
  logic spur_wire_switch_en, spur_correction_en, am_lo_tick;
  logic      ev [4];
  logic      tk [4];
  bit        st [4];
  int        cnt [4];
  int        acc [4];
  int        nev [4];
  int        num_errors;
  int        cmp_count;
  pllc_exp_t exq [4][$];

  pllc_core #(.FAST_DLY1(D1), .FAST_DLY2(D2), .FAST_DLY3(D3)) dut (
    .clk(clk), .rst(rst), .ctrl_word(ctrl_word), .ctrl_load(ctrl_load), .vco_tick(vco_tick),
    .ref_tick(ref_tick), .am_ratio(am_ratio), .fb_div_pulse(fb_div_pulse), .ref_div_pulse(ref_div_pulse),
    .pump_source(pump_source), .pump_sink(pump_sink), .high_pump_en(high_pump_en),
    .high_pump_2ma(high_pump_2ma), .low_pump_100ua(low_pump_100ua), .loop_filter_sel(loop_filter_sel),
    .spur_wire_switch_en(spur_wire_switch_en), .spur_correction_en(spur_correction_en),
    .fast_pump_active(fast_pump_active), .am_lo_tick(am_lo_tick));
  pllc_analog_model u_model (.clk(clk), .rst(rst), .slow(slow), .pump_source(pump_source),
    .pump_sink(pump_sink), .vco_tick(vco_tick), .ref_tick(ref_tick));

  always #5 clk = ~clk;

  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_num(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_num

  task automatic cmp_bits(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bits

  task automatic expect_win(input int ch, input int k, input int total);
    exq[ch].push_back('{k, total});
  endtask : expect_win

  task automatic wait_done();
    int left;
    left = 1;
    for (int i = 0; i < 4000 && left > 0; i++) begin
      @(negedge clk);
      left = exq[0].size() + exq[1].size() + exq[2].size() + exq[3].size();
    end
    cmp_num(left, 0);
    foreach (exq[i]) exq[i].delete();
    // A timed-out window must not leave a channel armed against an empty queue
    foreach (st[i]) st[i] = 1'b0;
  endtask : wait_done

  // Random frame, then the fields under test; the unselected slot gets ~n
  task automatic load(input logic [N_W-1:0] n, input logic [R_W-1:0] r, input logic shf, input logic frc,
                      input logic [3:0] dly, input logic dsel, input logic ehp);
    logic [WORD_W-1:0] w;
    w = WORD_W'({$urandom, $urandom, $urandom, $urandom, $urandom});
    w[BIT_N1_LO +: N_W] = w[BIT_SEL_N] ? ~n : n;
    w[BIT_N2_LO +: N_W] = w[BIT_SEL_N] ? n : ~n;
    w[BIT_R_LO +: R_W] = r;
    w[BIT_SHIFT] = shf;
    w[BIT_FRAC] = frc;
    w[BIT_DLY1_LO +: 4] = dly;
    w[BIT_DLY_SEL] = dsel;
    ctrl_word = w;
    ctrl_load = 1'b1;
    @(negedge clk);
    ctrl_load = 1'b0;
    @(negedge clk);
    cmp_bits({high_pump_en, fast_pump_active, high_pump_2ma, low_pump_100ua, loop_filter_sel,
              spur_wire_switch_en, spur_correction_en},
             {ehp, ehp, w[BIT_HC_SEL], w[BIT_LC_SEL], w[BIT_LF_SEL], w[BIT_SPUR], w[BIT_SPUR]});
    repeat (40) @(negedge clk);
  endtask : load

  // Counts ticks over k whole periods, starting at the next event.
  // Falling edge: registered outputs are settled, and the tick read with a pulse closes its period
  always @(negedge clk) begin
    ev = '{fb_div_pulse, ref_div_pulse, am_lo_tick, high_pump_en != hp_d};
    tk = '{vco_tick, ref_tick, vco_tick, hp_d};
    for (int i = 0; i < 4; i++) begin
      cnt[i] += int'(tk[i]);
      if (ev[i] === 1'b1) begin
        if (st[i]) begin
          acc[i] += cnt[i];
          nev[i]++;
          if (nev[i] == exq[i][0].k) begin
            cmp_num(acc[i], exq[i][0].total);
            void'(exq[i].pop_front());
            st[i] = 1'b0;
          end
        end else if (exq[i].size() > 0) begin
          st[i] = 1'b1;
          acc[i] = 0;
          nev[i] = 0;
        end
        cnt[i] = 0;
      end
    end
    hp_d = high_pump_en;
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    ctrl_load = 1'b0;
    ctrl_word = '0;
    am_ratio = 4'h0;
    hp_d = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    void'($urandom(12));
    cmp_bits({high_pump_en, fast_pump_active, high_pump_2ma, low_pump_100ua, loop_filter_sel,
              spur_wire_switch_en, spur_correction_en}, 7'h00);
    expect_win(3, 1, D1);
    load(18'h5, 14'h5, 1'b1, 1'b1, 4'h1, 1'b0, 1'b1);
    expect_win(3, 1, D2);
    load(18'h6, 14'h5, 1'b1, 1'b1, 4'h8, 1'b1, 1'b1);
    expect_win(3, 1, D3);
    load(18'h7, 14'h5, 1'b1, 1'b1, 4'hc, 1'b1, 1'b1);
    wait_done();
    load(18'h9, 14'h5, 1'b1, 1'b1, 4'hc, 1'b0, 1'b0);
    load(18'h9, 14'h5, 1'b1, 1'b1, 4'h1, 1'b0, 1'b0);
    for (int f = 0; f < 4; f++) begin
      slow = f[1];
      load(18'(12 + f), 14'hc, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
      expect_win(0, 4, 12 + f);
      expect_win(1, 2, 6);
      wait_done();
      load(18'(12 + f), 14'(12 + f), 1'b0, 1'b1, 4'h0, 1'b0, 1'b0);
      expect_win(0, 4, 12);
      expect_win(1, 2, 6);
      wait_done();
    end
    load(18'h5, 14'h7, 1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
    expect_win(0, 2, 10);
    expect_win(1, 2, 14);
    wait_done();
    for (int i = 0; i < 4; i++) begin
      am_ratio = (i == 3) ? 4'h0 : PRE_W'(2 + $urandom_range(8));
      repeat (30) @(negedge clk);
      expect_win(2, 2, (am_ratio == 4'h0) ? 2 : 2 * int'(am_ratio));
      wait_done();
    end
    print_verdict();
  end

  // A hang counts as a mismatch
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : pllc_core_tb_top
`default_nettype wire
